// ==== inc/mea_regs.svh ====
// Purpose: Register offsets, field positions and timing counts of the media codec.
// Assumes: APB with 32-bit data, 125 MHz pclk.
// Notes:   Timing counts are derived from printed times and the clock rate.
`ifndef MEA_REGS_SVH
`define MEA_REGS_SVH

`define MEA_CLK_HZ        125000000
`define MEA_ADDR_W        8

`define MEA_CTRL_OFS      8'h00
`define MEA_STAT_OFS      8'h04
`define MEA_IRQ_OFS       8'h08
`define MEA_MASK_OFS      8'h0C

`define MEA_CTRL_AUI      0
`define MEA_CTRL_AUTO     4
`define MEA_CTRL_RST      32'h0000_0000

`define MEA_IRQ_MED       0
`define MEA_IRQ_JAB       1
`define MEA_IRQ_COL       2
`define MEA_IRQ_LINK      3
`define MEA_NIRQ          4

`define MEA_JAB_MS        26
`define MEA_UNJAB_MS      750
`define MEA_LLOSS_MS      50
`define MEA_MS_CYC(ms)    ((ms) * (`MEA_CLK_HZ / 1000))

`define MEA_MID_NS        75
`define MEA_EOF_NS        150
`define MEA_HALF_NS       50
`define MEA_COLH_NS       200
`define MEA_NS_CYC(ns)    (((ns) * (`MEA_CLK_HZ / 1000000)) / 1000)

`define MEA_VALID_BITS    6

`endif

// ==== inc/mea_pkg.sv ====
// Purpose: Types shared by the media codec.
// Assumes: Constants live in mea_regs.svh.
// Notes:   Types only.
package mea_pkg;
   typedef enum logic {MED_TP, MED_AUI} mea_med_t;

   typedef struct packed {
      logic p;
      logic n;
   } mea_pair_t;

   typedef struct packed {
      logic col;
      logic tx_act;
      logic rx_act;
      logic auto_en;
      logic jab;
      logic link;
      logic aui;
   } mea_stat_t;
endpackage

// ==== logic/mea_endec.sv ====
// Purpose: Manchester codec with twisted-pair / AUI auto-switch and status indicators.
// Assumes: Codec line and strap pins are asynchronous to pclk and pass a three-stage filter; APB pins do not.
// Notes:   The 20 MHz oscillator is sampled, not used as a clock.
//
// Function
// R1 - Auto-switch enabled by strap bit five at reset or control bit four.
// R2 - Auto-switch on and no link pulses: select AUI port.
// R3 - Auto-switch on and link pulses return: select twisted-pair port.
// R4 - Medium changes only between frames, never mid transmit or receive.
// R5 - Switch to AUI while jabbering waits for jabber end plus unjab time.
// R6 - Jabber after 26 ms transmit; re-enable after 750 ms of idle enable.
// R7 - Coax select output asserted when auto-switch picked the AUI port.
// R8 - Activity, collision and link indicators are open-drain sinks.
// R9 - Oscillator divided by two gives the 10 MHz transmit clock.
// R10 - Oscillator paces encoder, decoder and twisted-pair logic alike. Here it paces only the encoder; decoder, jabber and link timers count pclk.
// R11 - Encoder converts NRZ transmit data to Manchester on differential output.
// R12 - Zero is high then low; one is low then high.
// R13 - Idle transmit lines held equal: zero differential.
// R14 - Decoder recovers NRZ data and receive clock for the controller.
// R15 - Receive data declared valid after six decoded bit times.
// R16 - Decoder tolerates 20 ns edge jitter.
// R17 - End of frame when mid-bit transitions stop.
// R18 - AUI collision signal makes the controller back off and reschedule.
// R19 - Collision indicator follows collision input only during network activity.
`timescale 1ns/1ps
`default_nettype none
`include "mea_regs.svh"

module mea_endec #(
   parameter int unsigned JAB_CYC   = `MEA_MS_CYC(`MEA_JAB_MS),
   parameter int unsigned UNJAB_CYC = `MEA_MS_CYC(`MEA_UNJAB_MS),
   parameter int unsigned LLOSS_CYC = `MEA_MS_CYC(`MEA_LLOSS_MS)
) (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [`MEA_ADDR_W-1:0]    paddr,
   input  wire logic [31:0]               pwdata,
   output var  logic [31:0]               prdata,
   output var  logic                      pready,
   output var  logic                      pslverr,
   output var  logic                      irq,
   input  wire logic                      strap_addr_bit5,
   input  wire logic                      osc_in,
   output var  logic                      osc_out,
   output var  logic                      tx_clk_out,
   input  wire logic                      tx_en,
   input  wire logic                      tx_data,
   output var  logic                      rx_data_out,
   output var  logic                      rx_clk_out,
   output var  logic                      carrier_sense,
   output var  logic                      collision_out,
   output var  mea_pkg::mea_pair_t        tp_tx,
   input  wire logic                      tp_rx,
   input  wire logic                      tp_link_pulse,
   output var  mea_pkg::mea_pair_t        aui_tx,
   input  wire logic                      aui_rx,
   input  wire logic                      collision_diff_in,
   output var  logic                      coax_select,
   output var  logic                      activity_indicator_o,
   output var  logic                      activity_indicator_oe,
   output var  logic                      collision_indicator_o,
   output var  logic                      collision_indicator_oe,
   output var  logic                      link_good_indicator_o,
   output var  logic                      link_good_indicator_oe
);
   import mea_pkg::*;

   localparam int unsigned MID_CYC  = `MEA_NS_CYC(`MEA_MID_NS);
   localparam int unsigned EOF_CYC  = `MEA_NS_CYC(`MEA_EOF_NS);
   localparam int unsigned HALF_CYC = `MEA_NS_CYC(`MEA_HALF_NS);
   localparam int unsigned COLH_CYC = `MEA_NS_CYC(`MEA_COLH_NS);
   localparam int unsigned NS       = 7;

   if (JAB_CYC < 2 || UNJAB_CYC < 2 || LLOSS_CYC < 2) begin : g_chk
      $error("mea_endec: timing counts must be at least 2");
   end
   if (JAB_CYC >= 2**27 || UNJAB_CYC >= 2**27 || LLOSS_CYC >= 2**27) begin : g_chk2
      $error("mea_endec: timing counts exceed counter width");
   end

   // Input filter indices
   localparam int unsigned I_OSC = 0;
   localparam int unsigned I_TXE = 1;
   localparam int unsigned I_TXD = 2;
   localparam int unsigned I_RX  = 3;
   localparam int unsigned I_LNK = 4;
   localparam int unsigned I_CD  = 5;
   localparam int unsigned I_STR = 6;

   mea_med_t        med_q;
   logic [NS-1:0]   pins;
   logic [NS-1:0]   s1_q, s2_q, s3_q, f_q;

   assign pins = {strap_addr_bit5, collision_diff_in, tp_link_pulse,
                  (med_q == MED_AUI) ? aui_rx : tp_rx, tx_data, tx_en, osc_in};

   // A level change counts only once stages two and three agree
   for (genvar i = 0; i < NS; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            s1_q[i] <= 1'b0;
            s2_q[i] <= 1'b0;
            s3_q[i] <= 1'b0;
            f_q[i]  <= 1'b0;
         end else begin
            s1_q[i] <= pins[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) begin
               f_q[i] <= s3_q[i];
            end
         end
      end
   end

   // Strap is caught once, after the filter has settled
   // The filter output is valid only after its fourth edge, so wait for it
   logic [2:0] strap_cnt_q;
   logic       strap_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_cnt_q <= 3'h0;
         strap_q     <= 1'b0;
      end else if (strap_cnt_q != 3'h5) begin
         strap_cnt_q <= strap_cnt_q + 3'h1;
         if (strap_cnt_q == 3'h4) begin
            strap_q <= f_q[I_STR];
         end
      end
   end

   // APB register file
   logic [31:0]          ctrl_q;
   logic [`MEA_NIRQ-1:0] ist_q, imask_q, ev;
   mea_stat_t            stat;
   wire  acc      = psel & penable & pready;
   wire  wr       = acc & pwrite;
   wire  hit_ctrl = (paddr == `MEA_CTRL_OFS);
   wire  hit_stat = (paddr == `MEA_STAT_OFS);
   wire  hit_irq  = (paddr == `MEA_IRQ_OFS);
   wire  hit_mask = (paddr == `MEA_MASK_OFS);
   wire  hit_any  = hit_ctrl | hit_stat | hit_irq | hit_mask;
   wire  auto_en  = strap_q | ctrl_q[`MEA_CTRL_AUTO]; // see R1
   wire [31:0] rd_mux =
      hit_ctrl ? ctrl_q :
      hit_stat ? {25'h0, stat} :
      hit_irq  ? {28'h0, ist_q} :
      hit_mask ? {28'h0, imask_q} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= psel & ~penable & ~pready;
         pslverr <= psel & ~penable & ~pready & ~hit_any;
         prdata  <= (psel & ~penable) ? rd_mux : prdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q  <= `MEA_CTRL_RST;
         imask_q <= 4'h0;
         ist_q   <= 4'h0;
         irq     <= 1'b0;
      end else begin
         if (wr && hit_ctrl) begin
            ctrl_q <= pwdata & 32'h0000_0011;
         end
         if (wr && hit_mask) begin
            imask_q <= pwdata[`MEA_NIRQ-1:0];
         end
         // A new event wins over a clear in the same cycle
         ist_q <= (ist_q & ~((wr && hit_irq) ? pwdata[`MEA_NIRQ-1:0] : 4'h0)) | ev;
         irq   <= |(ist_q & imask_q);
      end
   end

   // Oscillator halved to bit-cell phases and the transmit clock
   logic osc_prev_q, half_q, txa_q, txd_q, line_q;
   wire  osc_rise = f_q[I_OSC] & ~osc_prev_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_prev_q <= 1'b0;
         half_q     <= 1'b0;
         txa_q      <= 1'b0;
         txd_q      <= 1'b0;
         line_q     <= 1'b0;
         tx_clk_out <= 1'b0;
         osc_out    <= 1'b0;
      end else begin
         osc_prev_q <= f_q[I_OSC];
         osc_out    <= ~f_q[I_OSC];
         if (osc_rise) begin
            half_q     <= ~half_q;     // see R9 R10
            tx_clk_out <= ~half_q;     // see R9
            if (!half_q) begin
               txa_q  <= f_q[I_TXE];   // see R11
               txd_q  <= f_q[I_TXD];
               line_q <= ~f_q[I_TXD];  // see R12
            end else begin
               line_q <= txd_q;        // see R12
            end
         end
      end
   end

   // Jabber watchdog on the twisted-pair transmitter
   logic [26:0] jcnt_q, ucnt_q;
   logic        jab_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         jcnt_q <= 27'h0;
         ucnt_q <= 27'h0;
         jab_q  <= 1'b0;
      end else if (!jab_q) begin
         ucnt_q <= 27'h0;
         if (txa_q && med_q == MED_TP) begin
            jcnt_q <= jcnt_q + 27'h1;
            if (jcnt_q == 27'(JAB_CYC - 1)) begin
               jab_q <= 1'b1;          // see R6
            end
         end else begin
            jcnt_q <= 27'h0;
         end
      end else begin
         jcnt_q <= 27'h0;
         // Any enable restarts the unjab wait
         if (f_q[I_TXE]) begin
            ucnt_q <= 27'h0;
         end else if (ucnt_q == 27'(UNJAB_CYC - 1)) begin
            jab_q  <= 1'b0;            // see R6
         end else begin
            ucnt_q <= ucnt_q + 27'h1;
         end
      end
   end

   // Link integrity from received link pulses
   logic [26:0] lcnt_q;
   logic        link_q, lp_prev_q;
   wire         lp_rise = f_q[I_LNK] & ~lp_prev_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lcnt_q    <= 27'h0;
         link_q    <= 1'b0;
         lp_prev_q <= 1'b0;
      end else begin
         lp_prev_q <= f_q[I_LNK];
         if (lp_rise) begin
            lcnt_q <= 27'h0;
            link_q <= 1'b1;
         end else if (lcnt_q == 27'(LLOSS_CYC - 1)) begin
            link_q <= 1'b0;
         end else begin
            lcnt_q <= lcnt_q + 27'h1;
         end
      end
   end

   // Decoder: edges later than 3/4 bit after the last mid-bit edge are
   // mid-bit edges; that margin absorbs the allowed jitter on both sides.
   logic       rx_prev_q, rxa_q;
   logic [4:0] since_q;
   logic [2:0] nbit_q;
   wire        rx_edge = f_q[I_RX] ^ rx_prev_q;
   wire        mid     = rx_edge & (~rxa_q | (since_q >= 5'(MID_CYC - 1))); // see R16
   wire        rx_end  = rxa_q & ~mid & (since_q >= 5'(EOF_CYC));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_prev_q     <= 1'b0;
         rxa_q         <= 1'b0;
         since_q       <= 5'h0;
         nbit_q        <= 3'h0;
         rx_data_out   <= 1'b0;
         rx_clk_out    <= 1'b0;
         carrier_sense <= 1'b0;
      end else begin
         rx_prev_q <= f_q[I_RX];
         if (mid) begin
            since_q     <= 5'h0;
            rxa_q       <= 1'b1;
            rx_data_out <= f_q[I_RX];  // see R14
            rx_clk_out  <= 1'b1;       // see R14
            if (nbit_q != 3'(`MEA_VALID_BITS)) begin
               nbit_q <= nbit_q + 3'h1;
            end
            if (nbit_q == 3'(`MEA_VALID_BITS - 1)) begin
               carrier_sense <= 1'b1;  // see R15
            end
         end else begin
            if (since_q != 5'h1F) begin
               since_q <= since_q + 5'h1;
            end
            if (since_q == 5'(HALF_CYC)) begin
               rx_clk_out <= 1'b0;
            end
            if (rx_end) begin
               rxa_q         <= 1'b0;  // see R17
               nbit_q        <= 3'h0;
               carrier_sense <= 1'b0;
               rx_clk_out    <= 1'b0;
            end
         end
      end
   end

   // Collision input: a 10 MHz burst keeps the hold timer refreshed
   logic       cd_prev_q, cola_q;
   logic [4:0] ccnt_q;
   wire        cd_edge = f_q[I_CD] ^ cd_prev_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cd_prev_q <= 1'b0;
         cola_q    <= 1'b0;
         ccnt_q    <= 5'h0;
      end else begin
         cd_prev_q <= f_q[I_CD];
         if (cd_edge) begin
            cola_q <= 1'b1;
            ccnt_q <= 5'h0;
         end else if (ccnt_q == 5'(COLH_CYC)) begin
            cola_q <= 1'b0;
         end else begin
            ccnt_q <= ccnt_q + 5'h1;
         end
      end
   end

   wire net_act = txa_q | rxa_q;
   wire col_now = (med_q == MED_AUI) ? cola_q : (txa_q & rxa_q);

   // Medium selection
   wire want_aui = auto_en ? ~link_q : ctrl_q[`MEA_CTRL_AUI];   // see R2 R3
   wire idle     = ~txa_q & ~rxa_q & ~f_q[I_TXE];              // see R4
   wire go_aui   = (med_q == MED_TP) & want_aui & idle & ~jab_q; // see R5
   wire go_tp    = (med_q == MED_AUI) & ~want_aui & idle;        // see R3 R4
   logic col_prev_q, link_prev_q, jab_prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         med_q <= MED_TP;
      end else begin
         unique case (med_q)
            MED_TP: begin
               if (go_aui) begin
                  med_q <= MED_AUI;
               end
            end
            MED_AUI: begin
               if (go_tp) begin
                  med_q <= MED_TP;
               end
            end
         endcase
      end
   end

   assign ev = {link_q ^ link_prev_q, col_now & ~col_prev_q,
                jab_q & ~jab_prev_q, go_aui | go_tp};

   assign stat = '{col: col_now, tx_act: txa_q, rx_act: rxa_q, auto_en: auto_en,
                   jab: jab_q, link: link_q, aui: (med_q == MED_AUI)};

   // Line drivers and indicators, all registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tp_tx                  <= '0;
         aui_tx                 <= '0;
         coax_select            <= 1'b0;
         collision_out          <= 1'b0;
         col_prev_q             <= 1'b0;
         link_prev_q            <= 1'b0;
         jab_prev_q             <= 1'b0;
         activity_indicator_o   <= 1'b0;
         activity_indicator_oe  <= 1'b0;
         collision_indicator_o  <= 1'b0;
         collision_indicator_oe <= 1'b0;
         link_good_indicator_o  <= 1'b0;
         link_good_indicator_oe <= 1'b0;
      end else begin
         col_prev_q  <= col_now;
         link_prev_q <= link_q;
         jab_prev_q  <= jab_q;
         // Idle lines sit equal so a transformer sees no differential
         tp_tx  <= (txa_q && med_q == MED_TP && !jab_q) ?
                   '{p: line_q, n: ~line_q} : '0;               // see R11 R13
         aui_tx <= (txa_q && med_q == MED_AUI) ?
                   '{p: line_q, n: ~line_q} : '0;               // see R11 R13
         coax_select   <= auto_en & (med_q == MED_AUI);         // see R7
         collision_out <= col_now;                              // see R18
         // Open drain: only ever sink, never drive high
         activity_indicator_o   <= 1'b0;                        // see R8
         activity_indicator_oe  <= net_act;
         collision_indicator_o  <= 1'b0;                        // see R8
         collision_indicator_oe <= col_now & net_act;           // see R19
         link_good_indicator_o  <= 1'b0;                        // see R8
         link_good_indicator_oe <= link_q;
      end
   end

endmodule
`default_nettype wire

// ==== bench/mea_endec_props.sv ====
// Purpose: Port-level assertions for the media codec.
// Assumes: One pclk domain, presetn asynchronous active low.
// Notes:   Bound into mea_endec after the module.
`timescale 1ns/1ps
`default_nettype none
module mea_endec_props (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic               tx_en,
   input wire logic               tx_clk_out,
   input wire logic               rx_clk_out,
   input wire logic               carrier_sense,
   input wire logic               coax_select,
   input wire mea_pkg::mea_pair_t tp_tx,
   input wire logic               activity_indicator_o,
   input wire logic               activity_indicator_oe,
   input wire logic               collision_indicator_o,
   input wire logic               collision_indicator_oe,
   input wire logic               link_good_indicator_o
);
   import mea_pkg::*;
   logic [5:0] idle_q;
   logic [5:0] idle_d;
   // Idle age of tx_en; 24 covers the pin filter plus the cell in flight
   assign idle_d = tx_en ? 6'h00 : ((idle_q == 6'h3F) ? idle_q : idle_q + 6'h01);
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         idle_q <= 6'h00;
      else
         idle_q <= idle_d;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   pready_first_a: assert property (psel && penable && !$past(penable) |-> pready)
      else $error("no pready in first access cycle");
   pready_once_a: assert property (pready |=> !pready)
      else $error("pready held beyond one cycle");
   slverr_pair_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   idle_equal_a: assert property (idle_q >= 6'h18 |-> tp_tx.p == tp_tx.n)
      else $error("idle transmit pair not equal");
   sink_only_a: assert property (!(activity_indicator_o || collision_indicator_o ||
      link_good_indicator_o))
      else $error("indicator drives high");
   txclk_rate_a: assert property ($rose(tx_clk_out) |-> ##[12:13] $rose(tx_clk_out))
      else $error("transmit clock not half the oscillator");
   rxclk_pulse_a: assert property ($rose(rx_clk_out) |-> rx_clk_out [*7] ##1 !rx_clk_out)
      else $error("receive clock pulse width wrong");
   carrier_bit_a: assert property ($rose(carrier_sense) |-> ##[0:2] rx_clk_out)
      else $error("carrier rose off a decoded bit");
   medium_frame_a: assert property ($changed(coax_select) |-> !carrier_sense && !tx_en)
      else $error("medium changed inside a frame");
   col_activity_a: assert property (collision_indicator_oe |-> activity_indicator_oe)
      else $error("collision indicator without activity");
endmodule
bind mea_endec mea_endec_props i_mea_endec_props (.pclk, .presetn, .psel, .penable, .pready,
   .pslverr, .tx_en, .tx_clk_out, .rx_clk_out, .carrier_sense, .coax_select, .tp_tx,
   .activity_indicator_o, .activity_indicator_oe, .collision_indicator_o,
   .collision_indicator_oe, .link_good_indicator_o);
`default_nettype wire

// ==== bench/mea_far_model.sv ====
// Purpose: Far-side transceiver: oscillator, link pulses, receive and collision pairs.
// Assumes: 1 ns time unit; pins are asynchronous to pclk.
// Notes:   A released receive line shows the inverse of its last level.
`timescale 1ns/1ps
`default_nettype none
module mea_far_model (
   input  wire logic link_on,
   input  wire logic col_on,
   output var  logic osc,
   output var  logic rx,
   output var  logic link_pulse,
   output var  logic col
);
   initial begin
      osc = 1'h0;
      rx = 1'h0;
      link_pulse = 1'h0;
      col = 1'h0;
   end
   // Free-running 20 MHz time base for the codec's encoder only
   always #25 osc = ~osc;
   always #50 col = col_on & ~col; // 10 MHz collision burst
   always begin
      #1000;
      if (link_on) begin
         link_pulse = 1'h1; // Pulses only while the cable is up
         #100;
         link_pulse = 1'h0;
      end
   end
   task automatic send(input logic [23:0] bits);
      int j;
      for (int i = 23; i >= 0; i--) begin
         j = $urandom_range(20);
         rx = ~bits[i]; // First half inverted
         #(40 + j);
         rx = bits[i]; // Mid-bit edge moved up to 10 ns either side of the cell centre
         #(60 - j);
      end
      rx = ~rx; // Edge at cell end only, so no extra mid-bit edge
   endtask
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: Self-checking bench for the media codec.
// Assumes: Jabber, unjab and link-loss counts shortened by parameter.
// Notes:   Random data from a fixed seed; hand-placed corner cases.
`timescale 1ns/1ps
`default_nettype none
`include "mea_regs.svh"
module tb;
   import mea_pkg::*;
   localparam int JAB = 2000;
   localparam int UNJ = 400;
   localparam int LLS = 300;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, strap, e;
   logic        tx_en, tx_data, tx_clk_out, rx_data_out, rx_clk_out, carrier_sense, b, nb;
   logic        collision_out, coax_select, osc, rx, lp, col, link_on, col_on, rxc_q;
   logic        act_o, act_oe, col_o, col_oe, lg_o, lg_oe, osc_out;
   logic [7:0]  paddr, rx_sh;
   logic [23:0] bits;
   logic [31:0] pwdata, prdata, d, r;
   mea_pair_t   tp_tx, aui_tx;
   int          n_fail, checked, cyc;
   mea_endec #(.JAB_CYC(JAB), .UNJAB_CYC(UNJ), .LLOSS_CYC(LLS)) i_mea_endec (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .irq, .strap_addr_bit5(strap), .osc_in(osc), .osc_out, .tx_clk_out,
      .tx_en, .tx_data, .rx_data_out, .rx_clk_out, .carrier_sense, .collision_out, .tp_tx,
      .tp_rx(rx), .tp_link_pulse(lp), .aui_tx, .aui_rx(rx), .collision_diff_in(col),
      .coax_select, .activity_indicator_o(act_o), .activity_indicator_oe(act_oe),
      .collision_indicator_o(col_o), .collision_indicator_oe(col_oe),
      .link_good_indicator_o(lg_o), .link_good_indicator_oe(lg_oe));
   mea_far_model i_mea_far_model (.link_on, .col_on, .osc, .rx, .link_pulse(lp), .col);
   initial pclk = 1'h0;
   always #4 pclk = ~pclk;
   function automatic logic [31:0] pair(input logic line);
      return {30'h0, line, ~line};
   endfunction
   function automatic logic [31:0] stat(input logic aui, input logic jab, input logic aut);
      return {28'h0, aut, jab, 1'h0, aui};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks=%0d mismatches=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Answer time is not assumed; only the bench timeout ends a wait
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      d = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wait_tc(input logic v);
      int n = 0;
      do @(negedge pclk); while (tx_clk_out !== v && ++n < 50);
      @(posedge pclk);
   endtask
   always @(negedge pclk) begin
      rxc_q <= rx_clk_out;
      if (rx_clk_out && !rxc_q)
         rx_sh <= {rx_sh[6:0], rx_data_out};
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, strap, tx_en, tx_data, col_on} = '0;
      paddr = '0;
      pwdata = '0;
      link_on = 1'h1;
      rxc_q = 1'h0;
      rx_sh = '0;
      d = $urandom(32'h09B5);
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      repeat (200) @(posedge pclk);
      apb(1'h0, `MEA_CTRL_OFS, 32'h0);
      chk(d, `MEA_CTRL_RST);
      apb(1'h0, `MEA_STAT_OFS, 32'h0);
      chk(d & 32'hD, stat(1'h0, 1'h0, 1'h0));
      apb(1'h1, 8'h10, 32'hFFFF_FFFF);
      apb(1'h0, 8'h10, 32'h0);
      chk({d[30:0], e}, 32'h1);
      r = $urandom;
      apb(1'h1, `MEA_MASK_OFS, r);
      apb(1'h0, `MEA_MASK_OFS, 32'h0);
      chk(d, r & 32'hF);
      $display("end registers");
      wait_tc(1'h1);
      wait_tc(1'h0);
      b = 1'($urandom);
      tx_data <= b;
      tx_en <= 1'h1;
      for (int i = 0; i < 8; i++) begin
         wait_tc(1'h1);
         @(negedge pclk);
         chk({29'h0, osc_out, tp_tx}, pair(~b));
         wait_tc(1'h0);
         nb = 1'($urandom);
         tx_data <= nb;
         tx_en <= (i < 7);
         repeat (3) @(negedge pclk);
         chk({30'h0, tp_tx}, pair(b));
         b = nb;
      end
      repeat (30) @(negedge pclk);
      chk({30'h0, tp_tx}, 32'h0);
      $display("end encoder");
      apb(1'h1, `MEA_MASK_OFS, 32'h1);
      apb(1'h1, `MEA_CTRL_OFS, 32'h1 << `MEA_CTRL_AUTO);
      tx_en <= 1'h1;
      repeat (JAB + 100) @(posedge pclk);
      apb(1'h0, `MEA_STAT_OFS, 32'h0);
      chk(d & 32'hD, stat(1'h0, 1'h1, 1'h1));
      chk({30'h0, tp_tx}, 32'h0);
      link_on <= 1'h0;
      repeat (LLS + 200) @(posedge pclk);
      tx_en <= 1'h0;
      repeat (UNJ / 2) @(negedge pclk);
      chk(coax_select, 1'h0);
      repeat (UNJ) @(negedge pclk);
      chk({irq, coax_select, lg_oe}, 3'h6);
      apb(1'h1, `MEA_IRQ_OFS, 32'h1);
      repeat (3) @(negedge pclk);
      chk(irq, 1'h0);
      $display("end jabber and switch");
      @(posedge pclk);
      col_on <= 1'h1;
      repeat (20) @(negedge pclk);
      chk(col_oe, 1'h0);
      @(posedge pclk);
      col_on <= 1'h0;
      bits = {16'hAAAA, 8'($urandom)};
      fork
         i_mea_far_model.send(bits);
         begin
            repeat (100) @(posedge pclk);
            col_on <= 1'h1;
            link_on <= 1'h1;
            repeat (20) @(negedge pclk);
            chk({collision_out, col_oe, act_oe}, 3'h7);
            @(posedge pclk);
            col_on <= 1'h0;
            repeat (120) @(negedge pclk);
            chk({carrier_sense, coax_select}, 2'h3);
         end
      join
      repeat (40) @(negedge pclk);
      chk({carrier_sense, coax_select, lg_oe, act_oe, aui_tx, rx_sh},
          {6'h08, bits[7:0]});
      $display("end receive");
      @(posedge pclk);
      strap <= 1'h1;
      presetn <= 1'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      repeat (20) @(posedge pclk);
      apb(1'h0, `MEA_STAT_OFS, 32'h0);
      chk(d & 32'h8, stat(1'h0, 1'h0, 1'h1));
      $display("end strap");
      results();
   end
endmodule
`default_nettype wire
